// File: common/spm_map.svh
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH
// sleep modes on mode_req
`define SPM_MODE_RUN 3'h0
`define SPM_MODE_IDLE 3'h1
`define SPM_MODE_DS1 3'h2
`define SPM_MODE_DS2 3'h3
`define SPM_MODE_DS0 3'h4
// reset cause codes
`define SPM_CAUSE_NONE 4'h0
`define SPM_CAUSE_HIGH_VOLTAGE_POWER_ON_RESET 4'h1
`define SPM_CAUSE_LOW_VOLTAGE_POWER_ON_RESET 4'h2
`define SPM_CAUSE_PIN 4'h3
`define SPM_CAUSE_WDOG 4'h4
`define SPM_CAUSE_SW 4'h5
`define SPM_CAUSE_OPTBYTE 4'h6
`define SPM_CAUSE_DEBUG 4'h7
`define SPM_CAUSE_DBGPORT 4'h8
`define SPM_CAUSE_DSLEEP 4'h9
// supply settle time on wake
`define SPM_SETTLE_NS 1000
`define SPM_CLK_NS 5
`define SPM_SETTLE_CYC ((`SPM_SETTLE_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_RESET_CYC 8
`define SPM_WDOG_DEFAULT 32'h0000_FFFF
`endif

// File: common/spm_pkg.sv
package spm_pkg;
    typedef enum logic [2:0] {
        SPM_RUN,
        SPM_IDLE,
        SPM_DS_ENTER,
        SPM_DS_SLEEP,
        SPM_DS_SETTLE,
        SPM_EMU
    } spm_state_t;
endpackage

// File: src/spm_power_manager.sv
// Purpose: sleep mode, power domain, reset and clock select control
// Assumes: all inputs synchronous to clk; clk is the always-on clock
// Notes: domain enables are level outputs toward the analog switches
// How it works
// - idle halts the processor; any pending interrupt resumes it.
// - idle keeps all domains powered and asserts no reset.
// - deep sleep 1 removes core power, sleep timer keeps counting.
// - deep sleep 2 also stops the sleep timer; only gpio can wake it.
// - emulated sleep keeps core powered, resets peripherals except debug units.
// - true deep sleep switches the flash domain off.
// - RAM powers down in deep sleep by default.
// - only retained RAM banks stay supplied from the low-leakage source.
// - always-on domain holds this logic and is never powered down.
// - both regulators are disabled in deep sleep.
// - wake sources depend on which deep sleep state is active.
// - all reset sources merge into one central reset logic.
// - the cause of the latest restart is recorded for software.
// - core power-up selects the 12 MHz RC oscillator.
// - software may switch the system clock to the 24 MHz crystal.
// - 32-bit sleep timer counts and wakes at a programmed time.
// - watchdog idle until enabled, then resets on software hang.
`timescale 1ns/1ps
`include "spm_map.svh"
module spm_power_manager
    import spm_pkg::*;
#(
    parameter int RAM_BANKS = 4,
    parameter int SETTLE_CYC = `SPM_SETTLE_CYC
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] mode_req,
    input wire logic sleep_go,
    input wire logic irq_pending,
    input wire logic [RAM_BANKS-1:0] ram_retain_sel,
    input wire logic gpio_wake,
    input wire logic [31:0] wake_compare,
    input wire logic wake_compare_en,
    input wire logic xtal_select,
    input wire logic xtal_ready,
    input wire logic high_voltage_power_on_reset,
    input wire logic low_voltage_power_on_reset,
    input wire logic external_reset_pin_n,
    input wire logic sw_reset_req,
    input wire logic option_byte_error,
    input wire logic debug_reset_req,
    input wire logic debug_port_reset,
    input wire logic wdog_enable,
    input wire logic wdog_kick,
    output logic cpu_halt,
    output logic core_power_en,
    output logic flash_power_en,
    output logic always_on_power_en,
    output logic [RAM_BANKS-1:0] ram_bank_power_en,
    output logic ram_retention_supply_en,
    output logic regulator_1v8_en,
    output logic regulator_1v25_en,
    output logic core_reset,
    output logic periph_reset,
    output logic debug_units_reset,
    output logic sysclk_is_xtal,
    output logic [3:0] reset_cause,
    output logic [31:0] sleep_count
);
    typedef struct packed {
        spm_state_t state;
        logic ds2;
        logic [15:0] timer;
        logic [3:0] rst_cnt;
        logic por_pending;
        logic cpu_halt;
        logic core_pwr;
        logic flash_pwr;
        logic [RAM_BANKS-1:0] ram_pwr;
        logic ret_sup;
        logic reg_en;
        logic core_rst;
        logic periph_rst;
        logic dbg_rst;
        logic xtal;
        logic [3:0] cause;
    } spm_pm_t;
    spm_pm_t st;
    spm_pm_t next_st;
    logic [31:0] timer_count;
    logic timer_match;
    logic timer_run;
    logic wdog_fire;
    logic [3:0] src_code;
    logic wake;
    // priority encoder over reset sources, also used for the cause latch
    function automatic logic [3:0] reset_code(input logic [8:0] s);
        if (s[0]) return `SPM_CAUSE_HIGH_VOLTAGE_POWER_ON_RESET;
        if (s[1]) return `SPM_CAUSE_LOW_VOLTAGE_POWER_ON_RESET;
        if (s[2]) return `SPM_CAUSE_PIN;
        if (s[3]) return `SPM_CAUSE_WDOG;
        if (s[4]) return `SPM_CAUSE_SW;
        if (s[5]) return `SPM_CAUSE_OPTBYTE;
        if (s[6]) return `SPM_CAUSE_DEBUG;
        if (s[7]) return `SPM_CAUSE_DBGPORT;
        if (s[8]) return `SPM_CAUSE_DSLEEP;
        return `SPM_CAUSE_NONE;
    endfunction
    // timer stops only in deep sleep 2
    assign timer_run = !((st.state == SPM_DS_SLEEP) && st.ds2);
    spm_sleep_timer #(
        .WIDTH(32)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .run(timer_run),
        .compare(wake_compare),
        .compare_en(wake_compare_en),
        .count(timer_count),
        .match(timer_match)
    );
    spm_watchdog u_wdog (
        .clk(clk),
        .rst_n(rst_n),
        .enable(wdog_enable),
        .kick(wdog_kick),
        .hold(st.state != SPM_RUN && st.state != SPM_IDLE),
        .fire(wdog_fire)
    );
    // gpio always wakes; the timer only outside deep sleep 2
    assign wake = gpio_wake || (timer_match && !st.ds2);
    assign src_code = reset_code({1'b0, debug_port_reset, debug_reset_req,
        option_byte_error, sw_reset_req, wdog_fire, !external_reset_pin_n,
        low_voltage_power_on_reset, high_voltage_power_on_reset});
    always_comb
    begin
        next_st = st;
        if (st.rst_cnt != 4'h0)
            next_st.rst_cnt = st.rst_cnt - 4'h1;
        if (st.por_pending)
        begin
            next_st.por_pending = 1'b0;
            next_st.cause = `SPM_CAUSE_HIGH_VOLTAGE_POWER_ON_RESET;
        end
        case (st.state)
            SPM_RUN:
            begin
                next_st.cpu_halt = 1'b0;
                if (sleep_go && mode_req == `SPM_MODE_IDLE)
                begin
                    next_st.state = SPM_IDLE;
                    next_st.cpu_halt = !irq_pending;
                    if (irq_pending)
                        next_st.state = SPM_RUN;
                end
                else if (sleep_go && (mode_req == `SPM_MODE_DS1 || mode_req == `SPM_MODE_DS2))
                begin
                    next_st.state = SPM_DS_ENTER;
                    next_st.ds2 = (mode_req == `SPM_MODE_DS2);
                    next_st.cpu_halt = 1'b1;
                end
                else if (sleep_go && mode_req == `SPM_MODE_DS0)
                begin
                    next_st.state = SPM_EMU;
                    next_st.cpu_halt = 1'b1;
                    next_st.periph_rst = 1'b1;
                end
            end
            SPM_IDLE:
            begin
                // domains untouched, resets untouched
                if (irq_pending)
                begin
                    next_st.state = SPM_RUN;
                    next_st.cpu_halt = 1'b0;
                end
            end
            SPM_DS_ENTER:
            begin
                next_st.state = SPM_DS_SLEEP;
                next_st.core_rst = 1'b1;
                next_st.core_pwr = 1'b0;
                next_st.flash_pwr = 1'b0;
                next_st.ram_pwr = ram_retain_sel;
                next_st.ret_sup = |ram_retain_sel;
                next_st.reg_en = 1'b0;
                next_st.xtal = 1'b0;
            end
            SPM_DS_SLEEP:
            begin
                if (wake)
                begin
                    next_st.state = SPM_DS_SETTLE;
                    next_st.reg_en = 1'b1;
                    next_st.core_pwr = 1'b1;
                    next_st.flash_pwr = 1'b1;
                    next_st.ram_pwr = '1;
                    next_st.ret_sup = 1'b0;
                    next_st.timer = 16'(SETTLE_CYC);
                end
            end
            SPM_DS_SETTLE:
            begin
                next_st.timer = st.timer - 16'h0001;
                if (st.timer == 16'h0000)
                begin
                    next_st.state = SPM_RUN;
                    next_st.core_rst = 1'b0;
                    next_st.cpu_halt = 1'b0;
                    next_st.cause = `SPM_CAUSE_DSLEEP;
                    next_st.xtal = 1'b0;
                end
            end
            SPM_EMU:
            begin
                if (wake || irq_pending)
                begin
                    next_st.state = SPM_RUN;
                    next_st.periph_rst = 1'b0;
                    next_st.cpu_halt = 1'b0;
                end
            end
            default:
                next_st.state = SPM_RUN;
        endcase
        // clock select only while running; xtal used once it is ready
        if (st.state == SPM_RUN && st.core_pwr)
            next_st.xtal = xtal_select && xtal_ready;
        if (src_code != `SPM_CAUSE_NONE)
        begin
            next_st.state = SPM_RUN;
            next_st.cause = src_code;
            next_st.rst_cnt = 4'(`SPM_RESET_CYC);
            next_st.core_rst = 1'b1;
            next_st.periph_rst = 1'b1;
            // debug units survive all but power-on and pin resets
            next_st.dbg_rst = (src_code <= `SPM_CAUSE_PIN);
            next_st.cpu_halt = 1'b0;
            next_st.core_pwr = 1'b1;
            next_st.flash_pwr = 1'b1;
            next_st.ram_pwr = '1;
            next_st.ret_sup = 1'b0;
            next_st.reg_en = 1'b1;
            next_st.xtal = 1'b0;
            next_st.ds2 = 1'b0;
        end
        else if (st.rst_cnt == 4'h1)
        begin
            next_st.core_rst = 1'b0;
            next_st.periph_rst = 1'b0;
            next_st.dbg_rst = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.state <= SPM_RUN;
            st.rst_cnt <= 4'(`SPM_RESET_CYC);
            st.por_pending <= 1'b1;
            st.core_pwr <= 1'b1;
            st.flash_pwr <= 1'b1;
            st.ram_pwr <= '1;
            st.reg_en <= 1'b1;
            st.core_rst <= 1'b1;
            st.periph_rst <= 1'b1;
            st.dbg_rst <= 1'b1;
        end
        else
            st <= next_st;
    end
    assign cpu_halt = st.cpu_halt;
    assign core_power_en = st.core_pwr;
    assign flash_power_en = st.flash_pwr;
    assign always_on_power_en = 1'b1;
    assign ram_bank_power_en = st.ram_pwr;
    assign ram_retention_supply_en = st.ret_sup;
    assign regulator_1v8_en = st.reg_en;
    assign regulator_1v25_en = st.reg_en;
    assign core_reset = st.core_rst;
    assign periph_reset = st.periph_rst;
    assign debug_units_reset = st.dbg_rst;
    assign sysclk_is_xtal = st.xtal;
    assign reset_cause = st.cause;
    assign sleep_count = timer_count;
    sequence ds_entry_s;
        st.state == SPM_DS_ENTER;
    endsequence
    sequence domains_off_s;
        !core_power_en && !flash_power_en && !regulator_1v8_en && !regulator_1v25_en;
    endsequence
    property ds_off_p;
        @(posedge clk) disable iff (!rst_n)
        (ds_entry_s and (src_code == `SPM_CAUSE_NONE)) |=> domains_off_s;
    endproperty
    ds_power_off_a: assert property (ds_off_p)
        else $error("domains not off after deep sleep entry");
    flash_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.state == SPM_DS_SLEEP |-> !flash_power_en)
        else $error("flash powered in deep sleep");
    reg_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.state == SPM_DS_SLEEP |-> !regulator_1v8_en && !regulator_1v25_en)
        else $error("regulator on in deep sleep");
    ram_retain_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ds_entry_s and (src_code == `SPM_CAUSE_NONE))
        |=> ram_bank_power_en == $past(ram_retain_sel))
        else $error("ram bank power not from retention selection");
    idle_power_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.state == SPM_IDLE |-> core_power_en && flash_power_en && !core_reset)
        else $error("idle removed power or asserted reset");
    idle_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.state == SPM_IDLE && irq_pending |=> !cpu_halt)
        else $error("idle did not resume on interrupt");
    emu_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.state == SPM_EMU |-> core_power_en && periph_reset && !debug_units_reset)
        else $error("emulated sleep reset wrong units");
    ds2_no_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.state == SPM_DS_SLEEP && st.ds2 && !gpio_wake && src_code == `SPM_CAUSE_NONE
        |=> st.state == SPM_DS_SLEEP)
        else $error("deep sleep 2 left without gpio wake");
    cause_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        src_code != `SPM_CAUSE_NONE |=> reset_cause == $past(src_code))
        else $error("reset cause not recorded");
    wake_settle_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.state == SPM_DS_SLEEP && wake && src_code == `SPM_CAUSE_NONE
        |=> core_reset && regulator_1v25_en && core_power_en)
        else $error("wake did not restore supplies under reset");
    rc_default_a: assert property (@(posedge clk) disable iff (!rst_n)
        src_code != `SPM_CAUSE_NONE |=> !sysclk_is_xtal)
        else $error("system clock not rc after reset");
endmodule // spm_power_manager

// File: src/spm_sleep_timer.sv
// Purpose: 32-bit sleep timer with compare wake
// Assumes: run gate from the manager
// Notes: counts on every clock while run is high
`timescale 1ns/1ps
`include "spm_map.svh"
module spm_sleep_timer
    import spm_pkg::*;
#(
    parameter int WIDTH = 32
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [WIDTH-1:0] compare,
    input wire logic compare_en,
    output logic [WIDTH-1:0] count,
    output logic match
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic match;
    } spm_st_t;
    spm_st_t st;
    spm_st_t next_st;
    always_comb
    begin
        next_st = st;
        next_st.match = 1'b0;
        if (run)
        begin
            next_st.count = st.count + 1'b1;
            next_st.match = compare_en && (st.count == compare);
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end
    assign count = st.count;
    assign match = st.match;
    stopped_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !run |=> (count == $past(count)) && !match)
        else $error("sleep timer moved while stopped");
endmodule // spm_sleep_timer

// File: src/spm_watchdog.sv
// Purpose: watchdog that fires a reset request on timeout
// Assumes: kick is a one-cycle pulse from software
// Notes: inactive until enabled; enable is sticky until reset
`timescale 1ns/1ps
`include "spm_map.svh"
module spm_watchdog
    import spm_pkg::*;
#(
    parameter logic [31:0] TIMEOUT = `SPM_WDOG_DEFAULT
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic kick,
    input wire logic hold,
    output logic fire
);
    typedef struct packed {
        logic armed;
        logic [31:0] count;
        logic fire;
    } spm_wd_t;
    spm_wd_t st;
    spm_wd_t next_st;
    always_comb
    begin
        next_st = st;
        next_st.fire = 1'b0;
        if (enable)
            next_st.armed = 1'b1;
        if (!st.armed || kick || hold)
            next_st.count = '0;
        else if (st.count >= TIMEOUT)
        begin
            next_st.fire = 1'b1;
            next_st.count = '0;
        end
        else
            next_st.count = st.count + 32'h0000_0001;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end
    assign fire = st.fire;
    idle_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
        !st.armed |=> !fire)
        else $error("watchdog fired before enable");
endmodule // spm_watchdog

// File: test/spm_power_manager_tb.sv
// Purpose: self-checking bench for the sleep, power and reset manager
// Assumes: inputs driven by non-blocking assignment at the rising edge
// Notes: settle count cut to 2 cycles; watchdog keeps its full timeout
`timescale 1ns/1ps
`include "spm_map.svh"
module testbench
    import spm_pkg::*;
;
    localparam int SETTLE = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] mode_req = 3'h0;
    logic sleep_go = 1'b0;
    logic irq_pending = 1'b0;
    logic [3:0] ram_retain_sel = 4'h0;
    logic gpio_wake = 1'b0;
    logic [31:0] wake_compare = 32'h0000_0000;
    logic wake_compare_en = 1'b0;
    logic xtal_select = 1'b0;
    logic xtal_ready = 1'b0;
    logic [6:0] rst_src = 7'h00;
    logic wdog_enable = 1'b0;
    logic wdog_kick = 1'b0;
    logic cpu_halt, core_power_en, flash_power_en, always_on_power_en;
    logic [3:0] ram_bank_power_en;
    logic ram_retention_supply_en, regulator_1v8_en, regulator_1v25_en;
    logic core_reset, periph_reset, debug_units_reset, sysclk_is_xtal;
    logic [3:0] reset_cause;
    logic [31:0] sleep_count;
    logic [3:0] codes [7] = '{`SPM_CAUSE_HIGH_VOLTAGE_POWER_ON_RESET, `SPM_CAUSE_LOW_VOLTAGE_POWER_ON_RESET, `SPM_CAUSE_PIN,
        `SPM_CAUSE_SW, `SPM_CAUSE_OPTBYTE, `SPM_CAUSE_DEBUG, `SPM_CAUSE_DBGPORT};
    int errors = 0;
    int n_tests = 0;

    always #2.5 clk = ~clk;

    spm_power_manager #(.RAM_BANKS(4), .SETTLE_CYC(SETTLE)) i_dut (
        .clk(clk), .rst_n(rst_n), .mode_req(mode_req), .sleep_go(sleep_go),
        .irq_pending(irq_pending), .ram_retain_sel(ram_retain_sel), .gpio_wake(gpio_wake),
        .wake_compare(wake_compare), .wake_compare_en(wake_compare_en),
        .xtal_select(xtal_select), .xtal_ready(xtal_ready),
        .high_voltage_power_on_reset(rst_src[0]), .low_voltage_power_on_reset(rst_src[1]),
        .external_reset_pin_n(~rst_src[2]), .sw_reset_req(rst_src[3]),
        .option_byte_error(rst_src[4]), .debug_reset_req(rst_src[5]),
        .debug_port_reset(rst_src[6]), .wdog_enable(wdog_enable), .wdog_kick(wdog_kick),
        .cpu_halt(cpu_halt), .core_power_en(core_power_en), .flash_power_en(flash_power_en),
        .always_on_power_en(always_on_power_en), .ram_bank_power_en(ram_bank_power_en),
        .ram_retention_supply_en(ram_retention_supply_en),
        .regulator_1v8_en(regulator_1v8_en), .regulator_1v25_en(regulator_1v25_en),
        .core_reset(core_reset), .periph_reset(periph_reset),
        .debug_units_reset(debug_units_reset), .sysclk_is_xtal(sysclk_is_xtal),
        .reset_cause(reset_cause), .sleep_count(sleep_count)
    );

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
            errors++;
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait for a level, a hang ends the run
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            step(1);
            n++;
        end
        if (s !== v)
        begin
            $display("BAD wait level expected %0b seen %0b", v, s);
            errors++;
            tally_and_finish();
        end
    endtask

    task go(input logic [2:0] m);
        @(posedge clk);
        mode_req <= m;
        sleep_go <= 1'b1;
        @(posedge clk);
        sleep_go <= 1'b0;
        #1;
    endtask

    task chk_on;
        chk("core_pwr", core_power_en, 1);
        chk("flash_pwr", flash_power_en, 1);
        chk("ram_pwr", ram_bank_power_en, 4'hF);
        chk("reg_1v8", regulator_1v8_en, 1);
        chk("reg_1v25", regulator_1v25_en, 1);
        chk("aon_pwr", always_on_power_en, 1);
    endtask

    task gpio_pulse_wake;
        @(posedge clk);
        gpio_wake <= 1'b1;
        @(posedge clk);
        gpio_wake <= 1'b0;
        #1;
        chk_on();
        chk("wake_rst", core_reset, 1);
        chk("wake_clk", sysclk_is_xtal, 0);
        step(SETTLE);
        chk("settle_rst", core_reset, 1);
        wait_lvl(core_reset, 1'b0, 4);
        chk("wake_cause", reset_cause, `SPM_CAUSE_DSLEEP);
        chk("wake_halt", cpu_halt, 0);
    endtask

    task t_idle;
        go(`SPM_MODE_IDLE);
        chk("idle_halt", cpu_halt, 1);
        step(5);
        chk("idle_hold", cpu_halt, 1);
        chk_on();
        chk("idle_rst", {core_reset, periph_reset, debug_units_reset}, 0);
        @(posedge clk);
        irq_pending <= 1'b1;
        step(1);
        wait_lvl(cpu_halt, 1'b0, 4);
        @(posedge clk);
        irq_pending <= 1'b0;
        $display("test idle done");
    endtask

    task t_xtal;
        @(posedge clk);
        xtal_select <= 1'b1;
        step(4);
        chk("xtal_unready", sysclk_is_xtal, 0);
        @(posedge clk);
        xtal_ready <= 1'b1;
        step(1);
        wait_lvl(sysclk_is_xtal, 1'b1, 4);
        $display("test xtal done");
    endtask

    task t_ds1;
        logic [31:0] c0;
        @(posedge clk);
        ram_retain_sel <= 4'h5;
        go(`SPM_MODE_DS1);
        chk("ds_halt", cpu_halt, 1);
        step(1);
        chk("ds_core", core_power_en, 0);
        chk("ds_flash", flash_power_en, 0);
        chk("ds_regs", {regulator_1v8_en, regulator_1v25_en}, 0);
        chk("ds_ram", ram_bank_power_en, 4'h5);
        chk("ds_ret", ram_retention_supply_en, 1);
        chk("ds_aon", always_on_power_en, 1);
        c0 = sleep_count;
        step(10);
        chk("ds1_count", sleep_count, c0 + 32'd10);
        gpio_pulse_wake();
        $display("test deep sleep 1 done");
    endtask

    task t_ds2;
        logic [31:0] c0;
        // count read off the edge, so the compare value is not a race
        c0 = sleep_count + 32'd20;
        @(posedge clk);
        ram_retain_sel <= 4'h0;
        wake_compare <= c0;
        wake_compare_en <= 1'b1;
        go(`SPM_MODE_DS2);
        step(1);
        chk("ds2_ram", ram_bank_power_en, 4'h0);
        c0 = sleep_count;
        step(40);
        chk("ds2_count", sleep_count, c0);
        chk("ds2_nowake", core_power_en, 0);
        gpio_pulse_wake();
        $display("test deep sleep 2 done");
    endtask

    task t_timer;
        logic [31:0] cmp;
        cmp = sleep_count + 32'd30;
        @(posedge clk);
        wake_compare <= cmp;
        go(`SPM_MODE_DS1);
        step(1);
        chk("tmr_sleep", core_power_en, 0);
        wait_lvl(core_power_en, 1'b1, 60);
        chk("tmr_late", sleep_count >= cmp, 1);
        wait_lvl(core_reset, 1'b0, SETTLE + 4);
        chk("tmr_cause", reset_cause, `SPM_CAUSE_DSLEEP);
        @(posedge clk);
        wake_compare_en <= 1'b0;
        $display("test timer wake done");
    endtask

    task t_emu;
        go(`SPM_MODE_DS0);
        chk("emu_periph", periph_reset, 1);
        chk("emu_debug", debug_units_reset, 0);
        chk("emu_core", core_power_en, 1);
        @(posedge clk);
        irq_pending <= 1'b1;
        step(1);
        wait_lvl(periph_reset, 1'b0, 20);
        @(posedge clk);
        irq_pending <= 1'b0;
        $display("test emulated sleep done");
    endtask

    task t_src(input logic [6:0] mask, input logic [3:0] code);
        @(posedge clk);
        rst_src <= mask;
        @(posedge clk);
        rst_src <= 7'h00;
        #1;
        chk("src_cause", reset_cause, code);
        chk("src_rst", {core_reset, periph_reset}, 2'b11);
        chk("src_dbg", debug_units_reset, code <= 4'h3);
        chk_on();
        step(5);
        chk("src_hold", core_reset, 1);
        wait_lvl(core_reset, 1'b0, 6);
    endtask

    task t_resets;
        for (int i = 0; i < 7; i++)
            t_src(7'h01 << i, codes[i]);
        t_src(7'h48, `SPM_CAUSE_SW);
        t_src(7'h06, `SPM_CAUSE_LOW_VOLTAGE_POWER_ON_RESET);
        $display("test reset sources done");
    endtask

    task t_wdog;
        int n;
        n = 0;
        repeat (300)
        begin
            step(1);
            n += (core_reset !== 1'b0);
        end
        chk("wdog_idle", n, 0);
        @(posedge clk);
        wdog_enable <= 1'b1;
        n = 0;
        // one kick early on must push the timeout back by about 1000 cycles
        while (core_reset !== 1'b1 && n < 70000)
        begin
            @(posedge clk);
            wdog_kick <= (n == 1000);
            #1;
            n++;
        end
        chk("wdog_fired", core_reset, 1);
        chk("wdog_cause", reset_cause, `SPM_CAUSE_WDOG);
        chk("wdog_early", n > 66000, 1);
        @(posedge clk);
        wdog_enable <= 1'b0;
        $display("test watchdog done");
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        chk("por_cause", reset_cause, `SPM_CAUSE_HIGH_VOLTAGE_POWER_ON_RESET);
        chk("por_rst", core_reset, 1);
        wait_lvl(core_reset, 1'b0, 12);
        chk("por_clk", sysclk_is_xtal, 0);
        chk_on();
        $display("test power on done");
        t_idle();
        t_xtal();
        t_ds1();
        t_ds2();
        t_timer();
        t_emu();
        t_resets();
        t_wdog();
        tally_and_finish();
    end
endmodule // testbench
